// *** rtl/nvmreg_cfg.svh ***
/*
  Offsets, field positions, reset values and timing counts of the register bank.
  Assumes inclusion by bare name from the design file; the package does not include it.
*/
`ifndef NVMREG_CFG_SVH
`define NVMREG_CFG_SVH
// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define NVMREG_OFS_BUF0    6'h00
`define NVMREG_OFS_BUF1    6'h01
`define NVMREG_OFS_BUF2    6'h02
`define NVMREG_OFS_BUF3    6'h03
`define NVMREG_OFS_FLAGS   6'h04
`define NVMREG_OFS_CMD     6'h05
`define NVMREG_OFS_PAGE    6'h07
`define NVMREG_OFS_ADC     6'h08
`define NVMREG_OFS_CHKT    6'h21
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define NVMREG_BUSY_BIT    7
`define NVMREG_DRDY_BIT    6
`define NVMREG_PGERR_BIT   5
`define NVMREG_MEMWR_BIT   4
`define NVMREG_RST_BIT     2
`define NVMREG_MEMERR_BIT  1
`define NVMREG_CRCERR_BIT  0
`define NVMREG_CONVERT_COMMAND_BIT    7
`define NVMREG_ERROR_FLAGS_CLEAR_BIT  4
`define NVMREG_SLEEP_BIT   3
`define NVMREG_RESET_FLAG_CLEAR_BIT  2
`define NVMREG_SOFTRST_BIT 1
`define NVMREG_SHDN_BIT    0
`define NVMREG_PAGE_MASK   8'h07
`define NVMREG_ADC_MASK    8'h77
`define NVMREG_FLAGS_MASK  8'hF7
// ----------------------------------------------------------------
// Reset values and channel codes
// ----------------------------------------------------------------
`define NVMREG_RST_BYTE    8'h00
`define NVMREG_FLAGS_RST   8'h04
`define NVMREG_CH_TEMP     3'h5
`define NVMREG_CH_GND      3'h7
// ----------------------------------------------------------------
// Timing: conversion 125/62.5/31.25/7.8125 ms at 50 ns per cycle
// ----------------------------------------------------------------
`define NVMREG_CLK_NS      50
`define NVMREG_CONVERT_COMMAND_US_00  125000
`define NVMREG_CONVERT_COMMAND_CYC_00 (`NVMREG_CONVERT_COMMAND_US_00 * 1000 / `NVMREG_CLK_NS)
`define NVMREG_INIT_CYC    16
`endif

// *** rtl/nvmreg_pkg.sv ***
/*
  Types of the register bank.
  Assumes nvmreg_cfg.svh is on the include path.
*/
`default_nettype none
package nvmreg_pkg;
  typedef enum logic [1:0] {
    NVMREG_IDLE = 2'b00,
    NVMREG_CONVERT_COMMAND = 2'b01,
    NVMREG_INIT = 2'b10,
    NVMREG_PROG = 2'b11
  } nvmreg_op_type;

  typedef struct packed {
    logic [31:0]   buf_word;
    logic [7:0]    flags;
    logic          convert_command;
    logic          sleep;
    logic          shdn;
    logic [2:0]    page;
    logic [7:0]    adc;
    logic [7:0]    chk_target;
    logic [7:0]    rdata;
    nvmreg_op_type op;
    logic [23:0]   cnt;
    logic [2:0]    sync_wake;
    logic          convert_command_act;
    logic          prog_act;
  } nvmreg_state_type;
endpackage
`default_nettype wire

// *** rtl/nvmreg_top.sv ***
/*
  Register bank: word buffer, flags, commands, page pointer, ADC setup.
  Assumes link decoder on same clock gives one-cycle write/read strobes;
  EEPROM engine reports done/error as same-clock pulses; CRC engine gives a result byte.
*/
// Contract
// - Buffer is four bytes, offset 0 least significant, offset 3 most.
// - Busy flag bit 7 set during init, conversion or program; auto clears.
// - Data-ready bit 6 shows ADC data; cleared when convert is set.
// - Page-lock error bit 5 set on write to a disabled page.
// - Memory-write bit 4 set on mapped write, cleared on mapped read or program end.
// - Reset flag bit 2 set after power-on or soft reset until clear.
// - EEPROM error bit 1 set on memory error, cleared only by error clear.
// - Buffer check error bit 0 set on CRC mismatch, cleared only by error clear.
// - Convert bit 7 starts conversion, sets busy, clears data-ready.
// - Conversion end clears convert and busy, sets data-ready.
// - Writing zero to convert aborts a running conversion.
// - Error clear bit 4 clears both error flags, self clears, reads zero.
// - Sleep bit 3 stops fast oscillator; link activity clears it; reads zero.
// - Reset flag clear bit 2 clears reset flag, self clears, reads zero.
// - Soft reset bit 1 self clears, sets reset and busy flags, busy until done.
// - Shutdown bit 0 powers down; cleared by power-on reset; reads zero.
// - Page register holds 3-bit pointer, upper bits read-only, resets zero.
// - ADC setup bit 6 selects supply or internal reference.
// - Speed field sets filter length and conversion time.
// - Channel code 101 selects die temperature, 111 ground, others reserved.
// - Command bit 7 is direction, bit 6 selects mapped space.
// - Target write compares CRC; with memory-write set, match and page unlocked, programs EEPROM.
`timescale 1ns/100ps
`default_nettype none
`include "nvmreg_cfg.svh"

module nvmreg_top
(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CMD_STB_I,
  input  wire logic [7:0]  CMD_BYTE_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        LINK_ACTIVITY_I,
  input  wire logic [7:0]  CHECK_RESULT_I,
  input  wire logic        PAGE_LOCKED_I,
  input  wire logic        MEM_ERR_I,
  input  wire logic        PROG_DONE_I,
  output logic [7:0]       RDATA_O,
  output logic [31:0]      BUFFER_O,
  output logic [2:0]       PAGE_O,
  output logic [7:0]       ADC_SETUP_O,
  output logic             CONVERT_COMMAND_ACTIVE_O,
  output logic             PROG_START_O,
  output logic             FAST_OSC_STOP_O,
  output logic             SHUTDOWN_O
);

  nvmreg_pkg::nvmreg_state_type s_r;
  nvmreg_pkg::nvmreg_state_type s_nxt;
  logic                         wr_unm;
  logic                         rd_unm;
  logic [5:0]                   addr;
  logic                         prog_go;
  logic [23:0]                  convert_command_cycles;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [23:0] convert_command_len(input logic [1:0] spd);
    case (spd)
      2'b00:   convert_command_len = 24'(`NVMREG_CONVERT_COMMAND_CYC_00);
      2'b01:   convert_command_len = 24'(`NVMREG_CONVERT_COMMAND_CYC_00 / 2);
      2'b10:   convert_command_len = 24'(`NVMREG_CONVERT_COMMAND_CYC_00 / 4);
      default: convert_command_len = 24'(`NVMREG_CONVERT_COMMAND_CYC_00 / 16);
    endcase
  endfunction

  assign addr        = CMD_BYTE_I[5:0];
  assign wr_unm      = CMD_STB_I && CMD_BYTE_I[7] && !CMD_BYTE_I[6];
  assign rd_unm      = CMD_STB_I && !CMD_BYTE_I[7] && !CMD_BYTE_I[6];
  assign convert_command_cycles = convert_command_len(s_r.adc[5:4]);
  assign prog_go     = wr_unm && addr == `NVMREG_OFS_CHKT && s_r.flags[`NVMREG_MEMWR_BIT]
                       && WDATA_I == CHECK_RESULT_I && !PAGE_LOCKED_I;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.sync_wake = {s_r.sync_wake[1:0], LINK_ACTIVITY_I};
    if (s_r.sync_wake[2])
    begin
      s_nxt.sleep = 1'b0;
    end
    // Operation sequencer
    case (s_r.op)
      nvmreg_pkg::NVMREG_CONVERT_COMMAND:
      begin
        if (!s_r.convert_command)
        begin
          s_nxt.op                        = nvmreg_pkg::NVMREG_IDLE;
          s_nxt.flags[`NVMREG_BUSY_BIT]   = 1'b0;
        end
        else if (s_r.cnt == 24'h000001)
        begin
          s_nxt.op                        = nvmreg_pkg::NVMREG_IDLE;
          s_nxt.convert_command                      = 1'b0;
          s_nxt.flags[`NVMREG_BUSY_BIT]   = 1'b0;
          s_nxt.flags[`NVMREG_DRDY_BIT]   = 1'b1;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 24'h000001;
        end
      end
      nvmreg_pkg::NVMREG_INIT:
      begin
        if (s_r.cnt == 24'h000001)
        begin
          s_nxt.op                      = nvmreg_pkg::NVMREG_IDLE;
          s_nxt.flags[`NVMREG_BUSY_BIT] = 1'b0;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 24'h000001;
        end
      end
      nvmreg_pkg::NVMREG_PROG:
      begin
        if (PROG_DONE_I)
        begin
          s_nxt.op                       = nvmreg_pkg::NVMREG_IDLE;
          s_nxt.flags[`NVMREG_BUSY_BIT]  = 1'b0;
          s_nxt.flags[`NVMREG_MEMWR_BIT] = 1'b0;
        end
      end
      default:
      begin
        s_nxt.op = nvmreg_pkg::NVMREG_IDLE;
      end
    endcase
    // Mapped space accesses
    if (CMD_STB_I && CMD_BYTE_I[6])
    begin
      s_nxt.flags[`NVMREG_MEMWR_BIT] = CMD_BYTE_I[7];
    end
    // Register writes; reserved bits dropped
    if (wr_unm)
    begin
      case (addr)
        `NVMREG_OFS_BUF0: s_nxt.buf_word[7:0]   = WDATA_I;
        `NVMREG_OFS_BUF1: s_nxt.buf_word[15:8]  = WDATA_I;
        `NVMREG_OFS_BUF2: s_nxt.buf_word[23:16] = WDATA_I;
        `NVMREG_OFS_BUF3: s_nxt.buf_word[31:24] = WDATA_I;
        `NVMREG_OFS_CMD:
        begin
          s_nxt.convert_command = WDATA_I[`NVMREG_CONVERT_COMMAND_BIT];
          if (WDATA_I[`NVMREG_CONVERT_COMMAND_BIT] && s_r.op == nvmreg_pkg::NVMREG_IDLE)
          begin
            s_nxt.op                      = nvmreg_pkg::NVMREG_CONVERT_COMMAND;
            s_nxt.cnt                     = convert_command_cycles;
            s_nxt.flags[`NVMREG_BUSY_BIT] = 1'b1;
            s_nxt.flags[`NVMREG_DRDY_BIT] = 1'b0;
          end
          if (WDATA_I[`NVMREG_ERROR_FLAGS_CLEAR_BIT])
          begin
            s_nxt.flags[`NVMREG_MEMERR_BIT] = 1'b0;
            s_nxt.flags[`NVMREG_CRCERR_BIT] = 1'b0;
          end
          if (WDATA_I[`NVMREG_RESET_FLAG_CLEAR_BIT])
          begin
            s_nxt.flags[`NVMREG_RST_BIT] = 1'b0;
          end
          if (WDATA_I[`NVMREG_SLEEP_BIT])
          begin
            s_nxt.sleep = 1'b1;
          end
          if (WDATA_I[`NVMREG_SHDN_BIT])
          begin
            s_nxt.shdn = 1'b1;
          end
          if (WDATA_I[`NVMREG_SOFTRST_BIT])
          begin
            s_nxt.op                      = nvmreg_pkg::NVMREG_INIT;
            s_nxt.cnt                     = 24'(`NVMREG_INIT_CYC);
            s_nxt.convert_command                    = 1'b0;
            s_nxt.flags[`NVMREG_BUSY_BIT] = 1'b1;
            s_nxt.flags[`NVMREG_RST_BIT]  = 1'b1;
          end
        end
        `NVMREG_OFS_PAGE: s_nxt.page = WDATA_I[2:0];
        `NVMREG_OFS_ADC:  s_nxt.adc  = WDATA_I & `NVMREG_ADC_MASK;
        `NVMREG_OFS_CHKT:
        begin
          s_nxt.chk_target = WDATA_I;
          if (s_r.flags[`NVMREG_MEMWR_BIT] && WDATA_I != CHECK_RESULT_I)
          begin
            s_nxt.flags[`NVMREG_CRCERR_BIT] = 1'b1;
          end
          if (s_r.flags[`NVMREG_MEMWR_BIT] && WDATA_I == CHECK_RESULT_I && PAGE_LOCKED_I)
          begin
            s_nxt.flags[`NVMREG_PGERR_BIT] = 1'b1;
          end
          if (prog_go && s_r.op == nvmreg_pkg::NVMREG_IDLE)
          begin
            s_nxt.op                      = nvmreg_pkg::NVMREG_PROG;
            s_nxt.flags[`NVMREG_BUSY_BIT] = 1'b1;
          end
        end
        default: s_nxt.rdata = s_r.rdata;
      endcase
    end
    // Hardware-set flags win over clears in the same cycle
    if (MEM_ERR_I)
    begin
      s_nxt.flags[`NVMREG_MEMERR_BIT] = 1'b1;
    end
    // Read data path; write-only command bits read back zero
    if (rd_unm)
    begin
      case (addr)
        `NVMREG_OFS_BUF0: s_nxt.rdata = s_r.buf_word[7:0];
        `NVMREG_OFS_BUF1: s_nxt.rdata = s_r.buf_word[15:8];
        `NVMREG_OFS_BUF2: s_nxt.rdata = s_r.buf_word[23:16];
        `NVMREG_OFS_BUF3: s_nxt.rdata = s_r.buf_word[31:24];
        `NVMREG_OFS_FLAGS: s_nxt.rdata = s_r.flags & `NVMREG_FLAGS_MASK;
        `NVMREG_OFS_CMD:  s_nxt.rdata = {s_r.convert_command, 7'h00};
        `NVMREG_OFS_PAGE: s_nxt.rdata = {5'h00, s_r.page};
        `NVMREG_OFS_ADC:  s_nxt.rdata = s_r.adc;
        `NVMREG_OFS_CHKT: s_nxt.rdata = s_r.chk_target;
        default:          s_nxt.rdata = `NVMREG_RST_BYTE;
      endcase
    end
    // Operation levels kept in flops so the outputs carry no decode glitches
    s_nxt.convert_command_act = s_nxt.op == nvmreg_pkg::NVMREG_CONVERT_COMMAND;
    s_nxt.prog_act = s_nxt.op == nvmreg_pkg::NVMREG_PROG;
  end

  // ----------------------------------------------------------------
  // State register; power-on reset sets the reset flag
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s_r       <= '0;
      s_r.flags <= `NVMREG_FLAGS_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign RDATA_O         = s_r.rdata;
  assign BUFFER_O        = s_r.buf_word;
  assign PAGE_O          = s_r.page;
  assign ADC_SETUP_O     = s_r.adc;
  assign CONVERT_COMMAND_ACTIVE_O   = s_r.convert_command_act;
  assign PROG_START_O    = s_r.prog_act;
  assign FAST_OSC_STOP_O = s_r.sleep;
  assign SHUTDOWN_O      = s_r.shdn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_busy_convert_command: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CONVERT_COMMAND_ACTIVE_O |-> s_r.flags[`NVMREG_BUSY_BIT]) else $error("busy low in conversion");
  a_drdy_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CONVERT_COMMAND_ACTIVE_O |-> !s_r.flags[`NVMREG_DRDY_BIT]) else $error("ready set in conversion");
  a_convert_command_end: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CONVERT_COMMAND_ACTIVE_O && s_r.convert_command && s_r.cnt == 24'h000001 && !CMD_STB_I |=>
    s_r.flags[`NVMREG_DRDY_BIT] && !s_r.convert_command) else $error("conversion end wrong");
  a_abort_convert_command: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CONVERT_COMMAND_ACTIVE_O && !s_r.convert_command |=> !CONVERT_COMMAND_ACTIVE_O) else $error("abort ignored");
  a_err_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    wr_unm && addr == `NVMREG_OFS_CMD && WDATA_I[`NVMREG_ERROR_FLAGS_CLEAR_BIT] && !MEM_ERR_I |=>
    s_r.flags[1:0] == 2'b00) else $error("errors not cleared");
  a_rst_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    wr_unm && addr == `NVMREG_OFS_CMD && WDATA_I[`NVMREG_RESET_FLAG_CLEAR_BIT]
    && !WDATA_I[`NVMREG_SOFTRST_BIT] |=> !s_r.flags[`NVMREG_RST_BIT]) else $error("rst flag");
  a_soft_rst: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    wr_unm && addr == `NVMREG_OFS_CMD && WDATA_I[`NVMREG_SOFTRST_BIT] |=>
    s_r.flags[`NVMREG_RST_BIT] && s_r.flags[`NVMREG_BUSY_BIT]) else $error("soft reset");
  a_page_ro: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    rd_unm && addr == `NVMREG_OFS_PAGE |=> RDATA_O[7:3] == 5'h00) else $error("page high bits");
  a_memwr_set: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CMD_STB_I && CMD_BYTE_I[7:6] == 2'b11 |=> s_r.flags[`NVMREG_MEMWR_BIT]) else $error("memwr");
  a_memwr_clr: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CMD_STB_I && CMD_BYTE_I[7:6] == 2'b01 |=> !s_r.flags[`NVMREG_MEMWR_BIT])
    else $error("memory-write flag kept");
  a_err_set_wins: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    MEM_ERR_I |=> s_r.flags[`NVMREG_MEMERR_BIT]) else $error("memory error lost");
  a_crc_err_set: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    wr_unm && addr == `NVMREG_OFS_CHKT && s_r.flags[`NVMREG_MEMWR_BIT]
    && WDATA_I != CHECK_RESULT_I |=> s_r.flags[`NVMREG_CRCERR_BIT])
    else $error("check error missing");
  a_page_err: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    wr_unm && addr == `NVMREG_OFS_CHKT && s_r.flags[`NVMREG_MEMWR_BIT]
    && WDATA_I == CHECK_RESULT_I && PAGE_LOCKED_I |=> s_r.flags[`NVMREG_PGERR_BIT])
    else $error("page error missing");
  a_prog_start: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    wr_unm && addr == `NVMREG_OFS_CHKT && s_r.flags[`NVMREG_MEMWR_BIT] && !PAGE_LOCKED_I
    && WDATA_I == CHECK_RESULT_I && s_r.op == nvmreg_pkg::NVMREG_IDLE |=>
    PROG_START_O && s_r.flags[`NVMREG_BUSY_BIT]) else $error("program not started");
  a_shdn_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    SHUTDOWN_O |=> SHUTDOWN_O) else $error("shutdown left without reset");
  a_sleep_wake: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_r.sync_wake[2] && !(wr_unm && addr == `NVMREG_OFS_CMD && WDATA_I[`NVMREG_SLEEP_BIT])
    |=> !FAST_OSC_STOP_O) else $error("sleep kept on activity");
  a_ctrl_read: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    rd_unm && addr == `NVMREG_OFS_CMD |=> RDATA_O[6:0] == 7'h00)
    else $error("command bits read back");
  c_convert_command_done: cover property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CONVERT_COMMAND_ACTIVE_O ##1 !CONVERT_COMMAND_ACTIVE_O && s_r.flags[`NVMREG_DRDY_BIT]);
  c_prog: cover property (@(posedge CLOCK_I) disable iff (!RST_N_I) PROG_START_O);
  c_init: cover property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_r.op == nvmreg_pkg::NVMREG_INIT);
  c_temp_channel: cover property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ADC_SETUP_O[2:0] == `NVMREG_CH_TEMP);
  c_sleep_wake: cover property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    FAST_OSC_STOP_O ##1 !FAST_OSC_STOP_O);

endmodule // nvmreg_top
`default_nettype wire

// *** test/nvmreg_host_model.sv ***
/*
  Host model on the link side: command bytes, write data and break pulses.
  Assumes one clock shared with the register bank; read data comes registered.
*/
`timescale 1ns/100ps
`default_nettype none
module nvmreg_host_model
#(
  parameter int LIGHT_WAKE_CYC = 4000,   // 200 us at 50 ns
  parameter int DEEP_WAKE_CYC  = 300000  // 15 ms at 50 ns
)
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            cmd_stb_o,
  output logic [7:0]      cmd_byte_o,
  output logic [7:0]      wdata_o,
  output logic            link_activity_o
);
  initial
  begin
    cmd_stb_o       = 1'b0;
    cmd_byte_o      = 8'h00;
    wdata_o         = 8'hA5;
    link_activity_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  // Released lines show the inverse so a stale value is never mistaken
  task automatic xfer(input logic wr, input logic map, input logic [5:0] ofs,
                      input logic [7:0] data);
    @(posedge clk_i);
    #2;
    cmd_stb_o  = 1'b1;
    cmd_byte_o = {wr, map, ofs};
    wdata_o    = wr ? data : ~wdata_o;
    @(posedge clk_i);
    #2;
    cmd_stb_o  = 1'b0;
    cmd_byte_o = ~cmd_byte_o;
    wdata_o    = ~wdata_o;
  endtask
  task automatic rd(input logic map, input logic [5:0] ofs, output logic [7:0] data);
    xfer(1'b0, map, ofs, 8'h00);
    @(posedge clk_i);
    data = rdata_i;
    #2;
  endtask
  task automatic brk;
    @(posedge clk_i);
    #2;
    link_activity_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #2;
    link_activity_o = 1'b0;
  endtask
  // First break carries no data, second one opens the next command
  task automatic wake(input int gap);
    brk();
    repeat (gap) @(posedge clk_i);
    brk();
  endtask
endmodule // nvmreg_host_model
`default_nettype wire

// *** test/testbench.sv ***
/*
  Self-checking bench of the register bank with the host model on the link.
  Assumes the bank runs from one 20 MHz clock; long conversions are not awaited.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [5:0] ofs;
    logic [7:0] wd;
    logic [7:0] exp;
  } nvmreg_row_type;
  logic clk = 1'b0, rst_n = 1'b0, stb, act, locked = 1'b0, mem_err = 1'b0, done = 1'b0;
  logic [7:0]  cbyte, wdata, rdata, adc, chk = 8'h00;
  logic [31:0] bufw;
  logic [2:0]  page;
  logic        convert_command, prog, osc_stop, shdn;
  int          error_cnt = 0, samples_checked = 0;
  nvmreg_row_type rows [12] = '{
    '{6'h00, 8'h11, 8'h11}, '{6'h01, 8'h22, 8'h22}, '{6'h02, 8'h33, 8'h33},
    '{6'h03, 8'h44, 8'h44}, '{6'h07, 8'hFF, 8'h07}, '{6'h07, 8'h05, 8'h05},
    '{6'h08, 8'hFF, 8'h77}, '{6'h08, 8'h75, 8'h75}, '{6'h08, 8'h07, 8'h07},
    '{6'h06, 8'h5A, 8'h00}, '{6'h04, 8'hFF, 8'h04}, '{6'h05, 8'h14, 8'h00}};
  always #25 clk = ~clk;
  nvmreg_top nvmreg_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .CMD_STB_I(stb),
    .CMD_BYTE_I(cbyte), .WDATA_I(wdata), .LINK_ACTIVITY_I(act), .CHECK_RESULT_I(chk),
    .PAGE_LOCKED_I(locked), .MEM_ERR_I(mem_err), .PROG_DONE_I(done), .RDATA_O(rdata),
    .BUFFER_O(bufw), .PAGE_O(page), .ADC_SETUP_O(adc), .CONVERT_COMMAND_ACTIVE_O(convert_command),
    .PROG_START_O(prog), .FAST_OSC_STOP_O(osc_stop), .SHUTDOWN_O(shdn));
  nvmreg_host_model host_inst (.clk_i(clk), .rdata_i(rdata), .cmd_stb_o(stb),
    .cmd_byte_o(cbyte), .wdata_o(wdata), .link_activity_o(act));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [5:0] ofs, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    host_inst.rd(1'b0, ofs, d);
    check({24'h0, d & m}, {24'h0, e});
  endtask
  task automatic wr(input logic [5:0] ofs, input logic [7:0] d);
    host_inst.xfer(1'b1, 1'b0, ofs, d);
    repeat (2) @(posedge clk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #2;
    s = 1'b1;
    @(posedge clk);
    #2;
    s = 1'b0;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #2;
    rst_n = 1'b1;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic       idle;
    do_reset();
    rd_chk(6'h04, 8'hFF, 8'h04);
    rd_chk(6'h07, 8'hFF, 8'h00);
    rd_chk(6'h08, 8'hFF, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].ofs, rows[i].wd);
      rd_chk(rows[i].ofs, 8'hFF, rows[i].exp);
    end
    check(bufw, 32'h44332211);
    check({21'h0, page, adc}, {21'h0, 3'h5, 8'h07});
    rd_chk(6'h04, 8'hFF, 8'h00);
    wr(6'h05, 8'h02);
    rd_chk(6'h04, 8'hFF, 8'h84);
    idle = 1'b0;
    for (int i = 0; i < 40 && !idle; i++)
    begin
      host_inst.rd(1'b0, 6'h04, d);
      idle = (d[7] === 1'b0);
    end
    check({31'h0, idle}, 32'h1);
    rd_chk(6'h04, 8'hFF, 8'h04);
    pulse(mem_err);
    wr(6'h05, 8'h04);
    rd_chk(6'h04, 8'hFF, 8'h02);
    wr(6'h05, 8'h10);
    rd_chk(6'h04, 8'hFF, 8'h00);
    // Error and clear on one edge: the error has to survive
    fork
      pulse(mem_err);
      host_inst.xfer(1'b1, 1'b0, 6'h05, 8'h10);
    join
    repeat (2) @(posedge clk);
    #2;
    rd_chk(6'h04, 8'hFF, 8'h02);
    wr(6'h05, 8'h10);
    rd_chk(6'h04, 8'hFF, 8'h00);
    host_inst.xfer(1'b1, 1'b1, 6'h00, 8'hAB);
    rd_chk(6'h04, 8'h10, 8'h10);
    chk = 8'h5A;
    wr(6'h21, 8'h00);
    rd_chk(6'h04, 8'h01, 8'h01);
    wr(6'h05, 8'h10);
    rd_chk(6'h04, 8'h01, 8'h00);
    locked = 1'b1;
    wr(6'h21, 8'h5A);
    rd_chk(6'h04, 8'h20, 8'h20);
    check({31'h0, prog}, 32'h0);
    locked = 1'b0;
    wr(6'h21, 8'h5A);
    check({31'h0, prog}, 32'h1);
    rd_chk(6'h04, 8'h80, 8'h80);
    pulse(done);
    rd_chk(6'h04, 8'h90, 8'h00);
    host_inst.xfer(1'b1, 1'b1, 6'h01, 8'hCD);
    host_inst.rd(1'b1, 6'h01, d);
    rd_chk(6'h04, 8'h10, 8'h00);
    wr(6'h05, 8'h80);
    check({31'h0, convert_command}, 32'h1);
    rd_chk(6'h04, 8'hC0, 8'h80);
    rd_chk(6'h05, 8'hFF, 8'h80);
    wr(6'h05, 8'h00);
    check({31'h0, convert_command}, 32'h0);
    rd_chk(6'h04, 8'h80, 8'h00);
    wr(6'h05, 8'h08);
    check({31'h0, osc_stop}, 32'h1);
    rd_chk(6'h05, 8'hFF, 8'h00);
    host_inst.wake(host_inst.LIGHT_WAKE_CYC);
    check({31'h0, osc_stop}, 32'h0);
    wr(6'h05, 8'h01);
    check({31'h0, shdn}, 32'h1);
    rd_chk(6'h05, 8'hFF, 8'h00);
    do_reset();
    check({31'h0, shdn}, 32'h0);
    rd_chk(6'h04, 8'hFF, 8'h04);
    final_report();
  end
endmodule // testbench
`default_nettype wire
